/* hw/tkpd_pkg.sv */
// constants for the touch and keypad power-down control block
package tkpd_pkg;
	// register map, 16-bit word addresses on the serial register port
	localparam logic [6:0]  ADDR_POWER_DOWN   = 7'h08;
	localparam logic [6:0]  ADDR_KEY_FIRST    = 7'h0A;
	localparam logic [6:0]  ADDR_KEY_SECOND   = 7'h0B;
	// field positions inside the power-down register
	localparam int          TOUCH_PD_BIT      = 0;
	localparam int          KEYPAD_PD_BIT     = 1;
	localparam int          PD_FIELD_W        = 2;
	localparam logic [1:0]  POWER_DOWN_RESET  = 2'h0;
	localparam logic [15:0] KEY_RESULT_EMPTY  = 16'h0000;
	// serial frame layout: read flag, 7 address bits, 16 data bits
	localparam int          CMD_BITS          = 8;
	localparam int          FRAME_BITS        = 24;
	localparam int          DATA_BITS         = 16;
	localparam logic [4:0]  CMD_LAST          = 5'h07;
	localparam logic [4:0]  FRAME_LAST        = 5'h17;
	localparam logic [4:0]  DATA_FIRST        = 5'h08;
	// widths of the pins handled here
	localparam int          COLUMN_COUNT      = 6;
	localparam int          PANEL_SWITCHES    = 4;
endpackage

/* hw/tkpd_serial_port.sv */
// serial register port: oversampled slave with 24-bit frames
`timescale 1ns/1ps
`default_nettype none
module tkpd_serial_port (
	input  wire logic        ref_clk,   // system clock
	input  wire logic        rst,       // async reset, active high
	input  wire logic        csn_pin,   // chip select pin, active low
	input  wire logic        sclk_pin,  // serial clock pin
	input  wire logic        din_pin,   // serial data in pin
	input  wire logic [15:0] rdata,     // read data for addr
	output logic       [6:0] addr,      // captured address
	output logic             rd_stb,    // read command taken
	output logic             wr_stb,    // write frame complete
	output logic      [15:0] wdata,     // write data
	output logic             dout,      // serial data out
	output logic             dout_oe_n  // dout enable, low drives
);
	logic [1:0]  csn_s;
	logic [2:0]  sclk_s;
	logic [1:0]  din_s;
	logic [4:0]  bit_cnt;
	logic [22:0] shift;
	logic [15:0] tx;
	logic        is_read;
	logic        rise;
	logic        fall;
	logic        active;

	// two stages on every pin; third sclk stage only feeds edge detect
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			csn_s  <= 2'h3;
			sclk_s <= 3'h0;
			din_s  <= 2'h0;
		end else begin
			csn_s  <= {csn_s[0], csn_pin};
			sclk_s <= {sclk_s[1:0], sclk_pin};
			din_s  <= {din_s[0], din_pin};
		end
	end

	assign active = ~csn_s[1];
	assign rise   = active & sclk_s[1] & ~sclk_s[2];
	assign fall   = active & ~sclk_s[1] & sclk_s[2];

	// input side: sample on rising sclk, decode command and frame end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bit_cnt <= 5'h00;
			shift   <= 23'h000000;
			addr    <= 7'h00;
			is_read <= 1'b0;
			rd_stb  <= 1'b0;
			wr_stb  <= 1'b0;
			wdata   <= 16'h0000;
		end else begin
			rd_stb <= 1'b0;
			wr_stb <= 1'b0;
			if (!active) begin
				bit_cnt <= 5'h00; // frame aborted or finished
			end else if (rise) begin
				shift <= {shift[21:0], din_s[1]};
				// stop one past the last bit so a stray extra clock never strobes again
				if (bit_cnt <= tkpd_pkg::FRAME_LAST)
					bit_cnt <= bit_cnt + 5'h01;
				if (bit_cnt == tkpd_pkg::CMD_LAST) begin
					addr    <= {shift[5:0], din_s[1]};
					is_read <= shift[6];
					rd_stb  <= shift[6];
				end
				if (bit_cnt == tkpd_pkg::FRAME_LAST) begin
					wdata  <= {shift[14:0], din_s[1]};
					wr_stb <= ~is_read; // extra clocks past 24 are ignored
				end
			end
		end
	end

	// output side: change dout on falling sclk, drive from the first read data bit until chip select rises
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tx        <= 16'h0000;
			dout      <= 1'b0;
			dout_oe_n <= 1'b1;
		end else if (!active) begin
			dout_oe_n <= 1'b1;
		end else if (fall && is_read && bit_cnt >= tkpd_pkg::DATA_FIRST) begin
			dout_oe_n <= 1'b0;
			if (bit_cnt == tkpd_pkg::DATA_FIRST) begin
				tx   <= rdata;
				dout <= rdata[15];
			end else begin
				tx   <= {tx[14:0], 1'b0};
				dout <= tx[14];
			end
		end
	end
endmodule // tkpd_serial_port
`default_nettype wire

/* hw/tkpd_power_ctrl.sv */
// power-down control of the touch screen and keypad scanner blocks
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - touch power-down set opens every panel driver switch.
// - touch powered down: pen detect off, pen interrupt held high.
// - keypad power-down set drives all six column outputs low while set.
// - keypad power-down stops scanning and empties both key result registers.
// - keypad power-down cleared resumes scanning and key reporting.
// - keypad powered down: keypad interrupt output stays inactive.
// - power-down register at 08H, bit1 keypad, bit0 touch, rest read zero.
module tkpd_power_ctrl #(
	parameter int COLS = tkpd_pkg::COLUMN_COUNT,   // keypad columns
	parameter int SWS  = tkpd_pkg::PANEL_SWITCHES  // panel driver switches
) (
	input  wire logic            ref_clk,                // 20 MHz clock
	input  wire logic            rst,                    // async reset, active high
	input  wire logic            csn_pin,                // serial select, active low
	input  wire logic            sclk_pin,               // serial clock
	input  wire logic            din_pin,                // serial data in
	output logic                 dout,                   // serial data out
	output logic                 dout_oe_n,              // dout enable, low drives
	input  wire logic [SWS-1:0]  panel_switch_req,       // switch closes asked by converter
	output logic      [SWS-1:0]  panel_switch_en,        // switch gate drives
	input  wire logic            pen_detect_pin,         // pen comparator, high on touch
	output logic                 pen_touch_irq_n,        // pen interrupt, active low
	input  wire logic [COLS-1:0] column_req,             // column levels from scanner
	output logic      [COLS-1:0] keypad_column_drives,   // column pins
	output logic                 scan_enable,            // scanner run permit
	input  wire logic            key_load,               // scanner result pulse
	input  wire logic [15:0]     key_code_first,         // first key result
	input  wire logic [15:0]     key_code_second,        // second key result
	output logic                 key_irq_n,              // keypad interrupt, active low
	output logic      [tkpd_pkg::PD_FIELD_W-1:0] power_down_state // power-down bits
);
	logic [tkpd_pkg::PD_FIELD_W-1:0] block_power_down_control;
	logic [15:0] key_result_first;
	logic [15:0] key_result_second;
	logic [6:0]  addr;
	logic        rd_stb;
	logic        wr_stb;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic [1:0]  pen_s;
	logic        touch_block_power_down;
	logic        keypad_block_power_down;

	assign touch_block_power_down  = block_power_down_control[tkpd_pkg::TOUCH_PD_BIT];
	assign keypad_block_power_down = block_power_down_control[tkpd_pkg::KEYPAD_PD_BIT];

	tkpd_serial_port u_port (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.csn_pin   (csn_pin),
		.sclk_pin  (sclk_pin),
		.din_pin   (din_pin),
		.rdata     (rdata),
		.addr      (addr),
		.rd_stb    (rd_stb),
		.wr_stb    (wr_stb),
		.wdata     (wdata),
		.dout      (dout),
		.dout_oe_n (dout_oe_n)
	);

	// read decode; unmapped addresses and upper register bits read zero
	always_comb begin
		unique case (addr)
			tkpd_pkg::ADDR_POWER_DOWN: rdata = {14'h0000, block_power_down_control};
			tkpd_pkg::ADDR_KEY_FIRST:  rdata = key_result_first;
			tkpd_pkg::ADDR_KEY_SECOND: rdata = key_result_second;
			default:                   rdata = 16'h0000;
		endcase
	end

	// power-down register, only the two low bits are stored
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			block_power_down_control <= tkpd_pkg::POWER_DOWN_RESET;
		else if (wr_stb && addr == tkpd_pkg::ADDR_POWER_DOWN)
			block_power_down_control <= wdata[tkpd_pkg::PD_FIELD_W-1:0];
	end

	// pen comparator is asynchronous to the clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			pen_s <= 2'h0;
		else
			pen_s <= {pen_s[0], pen_detect_pin};
	end

	// touch side gating; no path closes a switch while powered down
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			panel_switch_en <= '0;
			pen_touch_irq_n <= 1'b1;
		end else if (touch_block_power_down) begin
			panel_switch_en <= '0;
			pen_touch_irq_n <= 1'b1;
		end else begin
			panel_switch_en <= panel_switch_req;
			pen_touch_irq_n <= ~pen_s[1];
		end
	end

	// keypad columns and scan permit follow the power-down bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			keypad_column_drives <= '0;
			scan_enable          <= 1'b0;
		end else begin
			keypad_column_drives <= keypad_block_power_down ? '0 : column_req;
			scan_enable          <= ~keypad_block_power_down;
		end
	end

	// key results: cleared and frozen while powered down, so stale keys never show
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			key_result_first  <= tkpd_pkg::KEY_RESULT_EMPTY;
			key_result_second <= tkpd_pkg::KEY_RESULT_EMPTY;
		end else if (keypad_block_power_down) begin
			key_result_first  <= tkpd_pkg::KEY_RESULT_EMPTY;
			key_result_second <= tkpd_pkg::KEY_RESULT_EMPTY;
		end else if (key_load) begin
			key_result_first  <= key_code_first;
			key_result_second <= key_code_second;
		end
	end

	// keypad interrupt: new key wins over a read of the first result in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			key_irq_n <= 1'b1;
		else if (keypad_block_power_down)
			key_irq_n <= 1'b1;
		else if (key_load)
			key_irq_n <= 1'b0;
		else if (rd_stb && addr == tkpd_pkg::ADDR_KEY_FIRST)
			key_irq_n <= 1'b1;
	end

	// state export for the rest of the device
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			power_down_state <= tkpd_pkg::POWER_DOWN_RESET;
		else
			power_down_state <= block_power_down_control;
	end

	// checks
	property p_touch_switches_open;
		@(posedge ref_clk) disable iff (rst)
		$past(touch_block_power_down) |-> panel_switch_en == '0;
	endproperty
	a_touch_switches_open: assert property (p_touch_switches_open) else $error("panel switch closed in power down");

	property p_pen_irq_high;
		@(posedge ref_clk) disable iff (rst)
		touch_block_power_down [*2] |-> pen_touch_irq_n;
	endproperty
	a_pen_irq_high: assert property (p_pen_irq_high) else $error("pen interrupt active in power down");

	property p_columns_low;
		@(posedge ref_clk) disable iff (rst)
		$past(keypad_block_power_down) |-> keypad_column_drives == '0;
	endproperty
	a_columns_low: assert property (p_columns_low) else $error("keypad column driven in power down");

	property p_keys_cleared;
		@(posedge ref_clk) disable iff (rst)
		$rose(keypad_block_power_down) |=> key_result_first == 16'h0000 && key_result_second == 16'h0000 && !scan_enable;
	endproperty
	a_keys_cleared: assert property (p_keys_cleared) else $error("key data not cleared at power down");

	property p_key_resume;
		@(posedge ref_clk) disable iff (rst)
		!keypad_block_power_down && key_load |=> key_result_first == $past(key_code_first) && !key_irq_n && scan_enable;
	endproperty
	a_key_resume: assert property (p_key_resume) else $error("key report missing after power up");

	property p_key_irq_quiet;
		@(posedge ref_clk) disable iff (rst)
		keypad_block_power_down |=> key_irq_n;
	endproperty
	a_key_irq_quiet: assert property (p_key_irq_quiet) else $error("keypad interrupt in power down");

	property p_pd_write;
		@(posedge ref_clk) disable iff (rst)
		wr_stb && addr == tkpd_pkg::ADDR_POWER_DOWN |=> block_power_down_control == $past(wdata[1:0])
			##1 power_down_state == $past(wdata[1:0], 2);
	endproperty
	a_pd_write: assert property (p_pd_write) else $error("power-down register write lost");

	property p_touch_resume;
		@(posedge ref_clk) disable iff (rst)
		!touch_block_power_down |=> panel_switch_en == $past(panel_switch_req) && pen_touch_irq_n == !$past(pen_s[1]);
	endproperty
	a_touch_resume: assert property (p_touch_resume) else $error("touch block not restored");

	property p_scan_halted;
		@(posedge ref_clk) disable iff (rst)
		$past(keypad_block_power_down) |-> !scan_enable && key_result_second == tkpd_pkg::KEY_RESULT_EMPTY;
	endproperty
	a_scan_halted: assert property (p_scan_halted) else $error("scan running or key data kept in power down");

	property p_columns_follow;
		@(posedge ref_clk) disable iff (rst)
		!keypad_block_power_down |=> keypad_column_drives == $past(column_req);
	endproperty
	a_columns_follow: assert property (p_columns_follow) else $error("keypad columns not restored");

	property p_key_irq_source;
		@(posedge ref_clk) disable iff (rst)
		$fell(key_irq_n) |-> $past(key_load) && !$past(keypad_block_power_down);
	endproperty
	a_key_irq_source: assert property (p_key_irq_source) else $error("keypad interrupt without allowed key");

	property p_state_copy;
		@(posedge ref_clk) disable iff (rst)
		power_down_state == $past(block_power_down_control);
	endproperty
	a_state_copy: assert property (p_state_copy) else $error("power-down state export wrong");
endmodule // tkpd_power_ctrl
`default_nettype wire

/* bench/tkpd_host_model.sv */
// host-side serial master model for the power-down block
`timescale 1ns/1ps
`default_nettype none
module tkpd_host_model (
	input  wire logic ref_clk,   // system clock
	output logic      csn_pin,   // chip select, active low
	output logic      sclk_pin,  // serial clock
	output logic      din_pin,   // serial data to device
	input  wire logic dout,      // serial data from device
	input  wire logic dout_oe_n  // device drive enable, low drives
);
	logic last;
	logic line;
	// a released line shows the inverse of its last level, not a lucky guess
	always_ff @(posedge ref_clk) begin
		if (!dout_oe_n) last <= dout;
	end
	assign line = dout_oe_n ? ~last : dout;
	initial begin
		csn_pin = 1'b1;
		sclk_pin = 1'b0;
		din_pin = 1'b0;
	end
	// one 24-bit frame; six cycles a level keeps us well inside the 3-cycle floor
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] q);
		logic [23:0] f;
		f = {rd, a, wd};
		q = 16'h0000;
		@(negedge ref_clk);
		csn_pin = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			din_pin = f[i];
			repeat (6) @(negedge ref_clk);
			if (i < 16) q[i] = line;
			sclk_pin = 1'b1;
			repeat (6) @(negedge ref_clk);
			sclk_pin = 1'b0;
		end
		repeat (6) @(negedge ref_clk);
		csn_pin = 1'b1;
		repeat (6) @(negedge ref_clk);
	endtask
endmodule // tkpd_host_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the touch and keypad power-down block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        ref_clk, rst, csn_pin, sclk_pin, din_pin, dout, dout_oe_n;
	logic [3:0]  panel_switch_req, panel_switch_en;
	logic        pen_detect_pin, pen_touch_irq_n, scan_enable, key_load, key_irq_n;
	logic [5:0]  column_req, keypad_column_drives;
	logic [15:0] key_code_first, key_code_second, q;
	logic [1:0]  power_down_state;
	int          err_count, check_count;
	tkpd_power_ctrl dut (.ref_clk(ref_clk), .rst(rst), .csn_pin(csn_pin), .sclk_pin(sclk_pin),
		.din_pin(din_pin), .dout(dout), .dout_oe_n(dout_oe_n), .panel_switch_req(panel_switch_req),
		.panel_switch_en(panel_switch_en), .pen_detect_pin(pen_detect_pin), .pen_touch_irq_n(pen_touch_irq_n),
		.column_req(column_req), .keypad_column_drives(keypad_column_drives), .scan_enable(scan_enable),
		.key_load(key_load), .key_code_first(key_code_first), .key_code_second(key_code_second),
		.key_irq_n(key_irq_n), .power_down_state(power_down_state));
	tkpd_host_model host (.ref_clk(ref_clk), .csn_pin(csn_pin), .sclk_pin(sclk_pin), .din_pin(din_pin),
		.dout(dout), .dout_oe_n(dout_oe_n));
	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// write, then let the register and gated pins settle
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		host.xfer(1'b0, a, d, q);
		repeat (8) @(negedge ref_clk);
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [15:0] exp, input string what);
		host.xfer(1'b1, a, 16'h0000, q);
		chk(what, q, exp);
	endtask
	// one-cycle result pulse from the scanner
	task automatic key_pulse(input logic [15:0] a, input logic [15:0] b);
		@(negedge ref_clk);
		key_code_first = a;
		key_code_second = b;
		key_load = 1'b1;
		@(negedge ref_clk);
		key_load = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// watchdog: a hung run counts as a mismatch
	initial begin
		repeat (100000) @(posedge ref_clk);
		err_count++;
		wrap_up();
	end
	initial begin
		err_count = 0;
		check_count = 0;
		rst = 1'b1;
		panel_switch_req = 4'hA;
		pen_detect_pin = 1'b1;
		column_req = 6'h2D;
		key_load = 1'b0;
		key_code_first = 16'h0000;
		key_code_second = 16'h0000;
		repeat (6) @(negedge ref_clk);
		rst = 1'b0;
		repeat (6) @(negedge ref_clk);
		// reset state: both blocks powered up
		chk("state", {14'h0000, power_down_state}, 16'h0000);
		chk("switches", {12'h000, panel_switch_en}, 16'h000A);
		chk("pen irq", {15'h0000, pen_touch_irq_n}, 16'h0000);
		chk("columns", {10'h000, keypad_column_drives}, 16'h002D);
		rdchk(tkpd_pkg::ADDR_POWER_DOWN, 16'h0000, "pd reg");
		chk("dout oe", {15'h0000, dout_oe_n}, 16'h0001);
		$display("test reset state done");
		// both down, reserved bits written as ones
		wr(tkpd_pkg::ADDR_POWER_DOWN, 16'hFFFF);
		rdchk(tkpd_pkg::ADDR_POWER_DOWN, 16'h0003, "pd reg");
		chk("state", {14'h0000, power_down_state}, 16'h0003);
		chk("switches", {12'h000, panel_switch_en}, 16'h0000);
		chk("pen irq", {15'h0000, pen_touch_irq_n}, 16'h0001);
		chk("columns", {10'h000, keypad_column_drives}, 16'h0000);
		chk("scan", {15'h0000, scan_enable}, 16'h0000);
		key_pulse(16'h1234, 16'h5678);
		chk("key irq", {15'h0000, key_irq_n}, 16'h0001);
		rdchk(tkpd_pkg::ADDR_KEY_FIRST, tkpd_pkg::KEY_RESULT_EMPTY, "key first");
		wr(7'h09, 16'h0000);
		rdchk(tkpd_pkg::ADDR_POWER_DOWN, 16'h0003, "pd reg");
		rdchk(7'h10, 16'h0000, "unmapped");
		$display("test both down done");
		// keypad up, results loaded, then keypad down clears them
		wr(tkpd_pkg::ADDR_POWER_DOWN, 16'h0001);
		chk("switches", {12'h000, panel_switch_en}, 16'h0000);
		chk("columns", {10'h000, keypad_column_drives}, 16'h002D);
		chk("scan", {15'h0000, scan_enable}, 16'h0001);
		key_pulse(16'hA5C3, 16'h3C5A);
		chk("key irq", {15'h0000, key_irq_n}, 16'h0000);
		rdchk(tkpd_pkg::ADDR_KEY_SECOND, 16'h3C5A, "key second");
		wr(tkpd_pkg::ADDR_POWER_DOWN, 16'h0002);
		chk("key irq", {15'h0000, key_irq_n}, 16'h0001);
		rdchk(tkpd_pkg::ADDR_KEY_FIRST, tkpd_pkg::KEY_RESULT_EMPTY, "key first");
		chk("columns", {10'h000, keypad_column_drives}, 16'h0000);
		chk("switches", {12'h000, panel_switch_en}, 16'h000A);
		chk("pen irq", {15'h0000, pen_touch_irq_n}, 16'h0000);
		rdchk(tkpd_pkg::ADDR_KEY_SECOND, tkpd_pkg::KEY_RESULT_EMPTY, "key second");
		$display("test keypad cycle done");
		// both back up: reporting resumes, pen follows comparator
		wr(tkpd_pkg::ADDR_POWER_DOWN, 16'h0000);
		key_pulse(16'h0F0F, 16'hF0F0);
		chk("key irq", {15'h0000, key_irq_n}, 16'h0000);
		rdchk(tkpd_pkg::ADDR_KEY_FIRST, 16'h0F0F, "key first");
		chk("key irq", {15'h0000, key_irq_n}, 16'h0001);
		pen_detect_pin = 1'b0;
		repeat (6) @(negedge ref_clk);
		chk("pen irq", {15'h0000, pen_touch_irq_n}, 16'h0001);
		$display("test restore done");
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
